// ==== ecb_defs.svh ====
// Constants used by one or both ends of the edge-counted backlight link.
`ifndef ECB_DEFS_SVH
`define ECB_DEFS_SVH
`define ECB_CLK_MHZ 100
`define ECB_LAT_US 500
`define ECB_OFF_US 500
`define ECB_LAT_CYCLES (`ECB_LAT_US * `ECB_CLK_MHZ)
`define ECB_OFF_CYCLES (`ECB_OFF_US * `ECB_CLK_MHZ)
`define ECB_HOLD_MARGIN 16
`define ECB_EDGE_LOW_NS 1000
`define ECB_EDGE_HIGH_NS 1000
`define ECB_EDGE_LOW_CYCLES ((`ECB_EDGE_LOW_NS * `ECB_CLK_MHZ) / 1000)
`define ECB_EDGE_HIGH_CYCLES ((`ECB_EDGE_HIGH_NS * `ECB_CLK_MHZ) / 1000)
`define ECB_CP_KHZ 900
`define ECB_CP_HALF_CYCLES ((`ECB_CLK_MHZ * 1000) / (2 * `ECB_CP_KHZ))
`define ECB_DATA_EDGES_MAX 5'h10
`define ECB_ADDR_EDGES_MIN 5'h11
`define ECB_ADDR_EDGES_MAX 5'h16
`define ECB_ADDR_BL 3'h0
`define ECB_ADDR_FLOOR 3'h1
`define ECB_ADDR_LVL_HI 3'h2
`define ECB_ADDR_LVL_LO 3'h3
`define ECB_ADDR_REG_EN 3'h4
`define ECB_ADDR_REG_V 3'h5
`define ECB_BL_OFF_BIT 2
`define ECB_FADE_EN_BIT 1
`define ECB_FADE_IN_BIT 0
`define ECB_RST_BL 3'h0
`define ECB_RST_FLOOR 2'h0
`define ECB_RST_LEVEL 5'h14
`define ECB_RST_LEVEL_HI 1'h1
`define ECB_RST_REG_EN 2'h0
`define ECB_RST_REG_V 4'h8
`define ECB_MASK_BL 4'h7
`define ECB_MASK_FLOOR 4'h3
`define ECB_MASK_LVL_HI 4'h1
`define ECB_MASK_FULL 4'hF
`define ECB_APB_CMD 8'h00
`define ECB_APB_CTRL 8'h04
`define ECB_APB_STATUS 8'h08
`define ECB_CMD_DATA_LSB 0
`define ECB_CMD_ADDR_LSB 4
`define ECB_CMD_WITH_ADDR_BIT 8
`define ECB_CTRL_SHUTDOWN_BIT 0
`endif

// ==== ecb_dev.sv ====
// Backlight device end: edge counter, timeouts, register bank and pump control.
//
// Implementation choice: the APB interface to the host command registers.
`timescale 1ns/1ps
`include "ecb_defs.svh"
module ecb_dev #(
  parameter int LAT_CYCLES = `ECB_LAT_CYCLES,
  parameter int OFF_CYCLES = `ECB_OFF_CYCLES,
  parameter int CW = 17
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  ecb_link_if.dev link,
  input wire logic cp_headroom_low_in,
  input wire logic cp_supply_high_in,
  output logic awake_out,
  output logic backlight_on_out,
  output logic fade_en_out,
  output logic fade_in_out,
  output logic [1:0] floor_code_out,
  output logic [4:0] led_level_code_out,
  output logic [8:0] led_target_tenth_ma_out,
  output logic regulator_a_on_out,
  output logic regulator_b_on_out,
  output logic regulator_a_discharge_out,
  output logic regulator_b_discharge_out,
  output logic [3:0] regulator_voltage_code_out,
  output logic cp_mode_1p5x_out,
  output logic cp_switch_out
);
  localparam logic [5:0] CP_HALF = 6'(`ECB_CP_HALF_CYCLES - 1);

  logic pin_q;
  logic shut;
  logic [CW-1:0] high_cnt;
  logic [CW-1:0] low_cnt;
  logic [4:0] edge_cnt;
  logic [2:0] addr_sel;
  logic [2:0] bl_ctrl;
  logic [1:0] floor_code;
  logic lvl_hi_hold;
  logic [4:0] level;
  logic [1:0] reg_en;
  logic [3:0] reg_v;
  logic cp_1p5x;
  logic [5:0] cp_div;

  // The current table is kept as arithmetic so every step rises by at least 0.5 mA.
  function automatic logic [8:0] level_to_tenth_ma(input logic [4:0] code);
    logic [8:0] ten_x;
    ten_x = 9'(code) * 9'h00A;
    if (code == 5'h00)
    begin
      level_to_tenth_ma = 9'h004;
    end
    else if (code == 5'h01)
    begin
      level_to_tenth_ma = 9'h009;
    end
    else if (code < 5'h06)
    begin
      level_to_tenth_ma = ten_x - 9'h001;
    end
    else
    begin
      level_to_tenth_ma = ten_x;
    end
  endfunction

  wire pin = link.ctrl_pin;
  wire rise = pin & ~pin_q;
  wire lat_fire = pin & (high_cnt == CW'(LAT_CYCLES - 1)) & (edge_cnt != 5'h00);
  wire off_fire = ~pin & (low_cnt == CW'(OFF_CYCLES - 1));
  wire wake = rise & shut;
  wire is_data = (edge_cnt != 5'h00) && (edge_cnt <= `ECB_DATA_EDGES_MAX);
  wire is_addr = (edge_cnt >= `ECB_ADDR_EDGES_MIN) && (edge_cnt <= `ECB_ADDR_EDGES_MAX);
  wire [4:0] data_m1 = edge_cnt - 5'h01;
  wire [4:0] addr_m = edge_cnt - `ECB_ADDR_EDGES_MIN;
  wire [3:0] wr_data = data_m1[3:0];
  wire wr_en = lat_fire & is_data;
  wire sel_en = lat_fire & is_addr;
  wire wr_bl = wr_en & (addr_sel == `ECB_ADDR_BL);
  wire wr_floor = wr_en & (addr_sel == `ECB_ADDR_FLOOR);
  wire wr_lvl_hi = wr_en & (addr_sel == `ECB_ADDR_LVL_HI);
  wire wr_lvl_lo = wr_en & (addr_sel == `ECB_ADDR_LVL_LO);
  wire wr_reg_en = wr_en & (addr_sel == `ECB_ADDR_REG_EN);
  wire wr_reg_v = wr_en & (addr_sel == `ECB_ADDR_REG_V);
  wire [4:0] next_edge_cnt = (off_fire | lat_fire) ? 5'h00 :
    (rise && edge_cnt != 5'h1F) ? edge_cnt + 5'h01 : edge_cnt;
  wire bl_on = ~shut & ~bl_ctrl[`ECB_BL_OFF_BIT];
  wire fading_out = bl_ctrl[`ECB_FADE_EN_BIT] & ~bl_ctrl[`ECB_FADE_IN_BIT];
  wire [8:0] floor_tenth = (floor_code == 2'h0) ? 9'h005 :
    (floor_code == 2'h1) ? 9'h00A :
    (floor_code == 2'h2) ? 9'h014 : 9'h01E;
  wire [8:0] next_target = bl_on ? level_to_tenth_ma(level) :
    (~shut & fading_out) ? floor_tenth : 9'h000;
  wire next_cp_1p5x = ~bl_on ? 1'b0 : cp_headroom_low_in ? 1'b1 :
    cp_supply_high_in ? 1'b0 : cp_1p5x;
  wire cp_run = bl_on & cp_1p5x;
  wire cp_tick = cp_div == CP_HALF;

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      pin_q <= 1'b0;
      high_cnt <= '0;
      low_cnt <= '0;
      edge_cnt <= 5'h00;
    end
    else
    begin
      pin_q <= pin;
      high_cnt <= (!pin) ? '0 : (high_cnt == CW'(LAT_CYCLES)) ? high_cnt : high_cnt + 1'b1;
      low_cnt <= pin ? '0 : (low_cnt == CW'(OFF_CYCLES)) ? low_cnt : low_cnt + 1'b1;
      edge_cnt <= next_edge_cnt;
    end
  end

  // Shutdown drops every setting back to its power-on value, as a real part loses it.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in || off_fire)
    begin
      shut <= 1'b1;
      addr_sel <= `ECB_ADDR_BL;
      bl_ctrl <= `ECB_RST_BL;
      floor_code <= `ECB_RST_FLOOR;
      lvl_hi_hold <= `ECB_RST_LEVEL_HI;
      level <= `ECB_RST_LEVEL;
      reg_en <= `ECB_RST_REG_EN;
      reg_v <= `ECB_RST_REG_V;
    end
    else
    begin
      if (wake)
      begin
        shut <= 1'b0;
        addr_sel <= `ECB_ADDR_BL;
        bl_ctrl <= `ECB_RST_BL;
        level <= `ECB_RST_LEVEL;
      end
      if (sel_en)
      begin
        addr_sel <= addr_m[2:0];
      end
      if (wr_bl)
      begin
        bl_ctrl <= wr_data[2:0];
      end
      if (wr_floor)
      begin
        floor_code <= wr_data[1:0];
      end
      if (wr_lvl_hi)
      begin
        lvl_hi_hold <= wr_data[0];
      end
      if (wr_lvl_lo)
      begin
        level <= {lvl_hi_hold, wr_data};
      end
      if (wr_reg_en)
      begin
        reg_en <= wr_data[1:0];
      end
      if (wr_reg_v)
      begin
        reg_v <= wr_data;
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      cp_1p5x <= 1'b0;
      cp_div <= 6'h00;
      cp_switch_out <= 1'b0;
    end
    else
    begin
      cp_1p5x <= next_cp_1p5x;
      cp_div <= (!cp_run || cp_tick) ? 6'h00 : cp_div + 6'h01;
      cp_switch_out <= !cp_run ? 1'b0 : cp_tick ? ~cp_switch_out : cp_switch_out;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      awake_out <= 1'b0;
      backlight_on_out <= 1'b0;
      fade_en_out <= 1'b0;
      fade_in_out <= 1'b0;
      floor_code_out <= `ECB_RST_FLOOR;
      led_level_code_out <= `ECB_RST_LEVEL;
      led_target_tenth_ma_out <= 9'h000;
      regulator_a_on_out <= 1'b0;
      regulator_b_on_out <= 1'b0;
      regulator_a_discharge_out <= 1'b1;
      regulator_b_discharge_out <= 1'b1;
      regulator_voltage_code_out <= `ECB_RST_REG_V;
      cp_mode_1p5x_out <= 1'b0;
    end
    else
    begin
      awake_out <= ~shut;
      backlight_on_out <= bl_on;
      fade_en_out <= bl_ctrl[`ECB_FADE_EN_BIT];
      fade_in_out <= bl_ctrl[`ECB_FADE_IN_BIT];
      floor_code_out <= floor_code;
      led_level_code_out <= level;
      led_target_tenth_ma_out <= next_target;
      regulator_a_on_out <= reg_en[1];
      regulator_b_on_out <= reg_en[0];
      regulator_a_discharge_out <= ~reg_en[1];
      regulator_b_discharge_out <= ~reg_en[0];
      regulator_voltage_code_out <= reg_v;
      cp_mode_1p5x_out <= cp_1p5x;
    end
  end
endmodule

// ==== ecb_host.sv ====
// Host end: APB command registers driving address and data edge bursts.
`timescale 1ns/1ps
`include "ecb_defs.svh"
module ecb_host #(
  parameter int LAT_HOLD_CYCLES = `ECB_LAT_CYCLES + `ECB_HOLD_MARGIN,
  parameter int OFF_HOLD_CYCLES = `ECB_OFF_CYCLES + `ECB_HOLD_MARGIN,
  parameter int EDGE_LOW_CYCLES = `ECB_EDGE_LOW_CYCLES,
  parameter int EDGE_HIGH_CYCLES = `ECB_EDGE_HIGH_CYCLES,
  parameter int TW = 17
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic busy_out,
  ecb_link_if.host link
);
  ecb_pkg::ecb_host_state_type state;
  logic [TW-1:0] timer;
  logic [4:0] edges_left;
  logic data_pending;
  logic [3:0] data_q;
  logic [8:0] cmd_q;

  wire setup = psel_in & ~penable_in;
  wire hit_cmd = paddr_in == `ECB_APB_CMD;
  wire hit_ctrl = paddr_in == `ECB_APB_CTRL;
  wire hit_status = paddr_in == `ECB_APB_STATUS;
  wire mapped = hit_cmd | hit_ctrl | hit_status;
  wire idle = state == ecb_pkg::ECB_IDLE;
  wire take = psel_in & penable_in & pready_out & pwrite_in & idle;
  wire go_cmd = take & hit_cmd;
  wire go_off = take & hit_ctrl & pwdata_in[`ECB_CTRL_SHUTDOWN_BIT];
  wire [2:0] cmd_addr = pwdata_in[`ECB_CMD_ADDR_LSB +: 3];
  wire [3:0] mask = (cmd_addr == `ECB_ADDR_BL) ? `ECB_MASK_BL :
    (cmd_addr == `ECB_ADDR_FLOOR) ? `ECB_MASK_FLOOR :
    (cmd_addr == `ECB_ADDR_LVL_HI) ? `ECB_MASK_LVL_HI :
    (cmd_addr == `ECB_ADDR_REG_EN) ? `ECB_MASK_FLOOR : `ECB_MASK_FULL;
  // Reserved bits are forced to zero so software slips cannot upset the device.
  wire [3:0] cmd_data = pwdata_in[`ECB_CMD_DATA_LSB +: 4] & mask;
  wire with_addr = pwdata_in[`ECB_CMD_WITH_ADDR_BIT];
  wire [4:0] addr_edges = {2'h0, cmd_addr} + `ECB_ADDR_EDGES_MIN;
  wire [4:0] data_edges = {1'b0, cmd_data} + 5'h01;
  wire [4:0] pend_edges = {1'b0, data_q} + 5'h01;
  wire tdone = timer == '0;
  wire [31:0] status_word = {30'h0000_0000, link.ctrl_pin, ~idle};
  wire [31:0] next_prdata = !setup ? prdata_out : hit_status ? status_word :
    hit_cmd ? {23'h00_0000, cmd_q} : 32'h0000_0000;

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end
    else
    begin
      pready_out <= setup;
      pslverr_out <= setup & ~mapped;
      prdata_out <= next_prdata;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      state <= ecb_pkg::ECB_IDLE;
      timer <= '0;
      edges_left <= 5'h00;
      data_pending <= 1'b0;
      data_q <= 4'h0;
      cmd_q <= 9'h000;
      busy_out <= 1'b0;
      link.ctrl_pin <= 1'b0;
    end
    else
    begin
      timer <= tdone ? timer : timer - 1'b1;
      busy_out <= ~idle | go_cmd | go_off;
      case (state)
        ecb_pkg::ECB_IDLE:
        begin
          if (go_cmd)
          begin
            cmd_q <= {with_addr, 1'b0, cmd_addr, cmd_data};
            data_q <= cmd_data;
            data_pending <= with_addr;
            edges_left <= with_addr ? addr_edges : data_edges;
            link.ctrl_pin <= 1'b0;
            timer <= TW'(EDGE_LOW_CYCLES - 1);
            state <= ecb_pkg::ECB_PULSE_LO;
          end
          else if (go_off)
          begin
            link.ctrl_pin <= 1'b0;
            timer <= TW'(OFF_HOLD_CYCLES - 1);
            state <= ecb_pkg::ECB_HOLD_LO;
          end
        end
        ecb_pkg::ECB_PULSE_LO:
        begin
          if (tdone)
          begin
            link.ctrl_pin <= 1'b1;
            edges_left <= edges_left - 5'h01;
            timer <= TW'(EDGE_HIGH_CYCLES - 1);
            state <= ecb_pkg::ECB_PULSE_HI;
          end
        end
        ecb_pkg::ECB_PULSE_HI:
        begin
          if (tdone && edges_left != 5'h00)
          begin
            link.ctrl_pin <= 1'b0;
            timer <= TW'(EDGE_LOW_CYCLES - 1);
            state <= ecb_pkg::ECB_PULSE_LO;
          end
          else if (tdone)
          begin
            timer <= TW'(LAT_HOLD_CYCLES - 1);
            state <= ecb_pkg::ECB_HOLD_HI;
          end
        end
        ecb_pkg::ECB_HOLD_HI:
        begin
          if (tdone && data_pending)
          begin
            data_pending <= 1'b0;
            edges_left <= pend_edges;
            link.ctrl_pin <= 1'b0;
            timer <= TW'(EDGE_LOW_CYCLES - 1);
            state <= ecb_pkg::ECB_PULSE_LO;
          end
          else if (tdone)
          begin
            state <= ecb_pkg::ECB_IDLE;
          end
        end
        ecb_pkg::ECB_HOLD_LO:
        begin
          if (tdone)
          begin
            state <= ecb_pkg::ECB_IDLE;
          end
        end
        default:
        begin
          state <= ecb_pkg::ECB_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== ecb_link_asserts.sv ====
// Concurrent checks on the control wire and the device outputs of the link.
`timescale 1ns/1ps
module ecb_link_asserts #(
  parameter int OFF_CYCLES = 200
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic ctrl_pin,
  input wire logic awake_out,
  input wire logic backlight_on_out,
  input wire logic fade_en_out,
  input wire logic fade_in_out,
  input wire logic [1:0] floor_code_out,
  input wire logic [4:0] led_level_code_out,
  input wire logic [8:0] led_target_tenth_ma_out,
  input wire logic regulator_a_on_out,
  input wire logic regulator_b_on_out,
  input wire logic regulator_a_discharge_out,
  input wire logic regulator_b_discharge_out,
  input wire logic cp_headroom_low_in,
  input wire logic cp_mode_1p5x_out,
  input wire logic cp_switch_out
);
  logic [17:0] low_cnt;
  logic [17:0] next_low_cnt;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  assign next_low_cnt = ctrl_pin ? 18'h0_0000 : low_cnt + 18'h0_0001;
  always_ff @(posedge ref_clk_in)
    low_cnt <= srst_in ? 18'h0_0000 : next_low_cnt;
  // Codes 2 to 5 sit a tenth below the linear line, so a plain 10c would hide a slip.
  function automatic logic [8:0] tenth(input logic [4:0] c);
    if (c < 5'h02)
      return (c == 5'h00) ? 9'h004 : 9'h009;
    return (c < 5'h06) ? 9'h00A * c - 9'h001 : 9'h00A * c;
  endfunction
  property p_discharge;
    regulator_a_discharge_out == !regulator_a_on_out &&
      regulator_b_discharge_out == !regulator_b_on_out;
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge not inverse");
  property p_wake;
    !awake_out && $rose(ctrl_pin) |->
      ##[1:4] (awake_out && backlight_on_out && led_level_code_out == 5'h14);
  endproperty
  a_wake: assert property (p_wake) else $error("wake defaults wrong");
  property p_off;
    low_cnt == OFF_CYCLES + 3 |-> !awake_out && !backlight_on_out;
  endproperty
  a_off: assert property (p_off) else $error("no shutdown after long low");
  property p_level;
    backlight_on_out && $stable(led_level_code_out) && $stable(backlight_on_out) |->
      led_target_tenth_ma_out == tenth(led_level_code_out);
  endproperty
  a_level: assert property (p_level) else $error("current target wrong");
  property p_floor;
    (awake_out && !backlight_on_out && fade_en_out && !fade_in_out)[*2] ##0
      $stable(floor_code_out) |-> led_target_tenth_ma_out ==
      ((floor_code_out == 2'h0) ? 9'h005 : 9'h00A * floor_code_out);
  endproperty
  a_floor: assert property (p_floor) else $error("fade floor wrong");
  property p_pump_up;
    (cp_headroom_low_in && backlight_on_out)[*3] |-> cp_mode_1p5x_out;
  endproperty
  a_pump_up: assert property (p_pump_up) else $error("pump not in 1.5x");
  property p_pump_idle;
    !awake_out[*3] |-> !cp_mode_1p5x_out && !cp_switch_out;
  endproperty
  a_pump_idle: assert property (p_pump_idle) else $error("pump active while shut");
  property p_pump_hold;
    $rose(cp_switch_out) |=> cp_switch_out[*8];
  endproperty
  a_pump_hold: assert property (p_pump_hold) else $error("pump phase too short");
  property p_on_awake;
    backlight_on_out |-> awake_out;
  endproperty
  a_on_awake: assert property (p_on_awake) else $error("backlight on while shut");
endmodule

// ==== ecb_link_if.sv ====
// Single control wire between the host controller and the backlight device.
`timescale 1ns/1ps
interface ecb_link_if;
  logic ctrl_pin;
  modport host (output ctrl_pin);
  modport dev (input ctrl_pin);
endinterface

// ==== ecb_pkg.sv ====
// Types used by the host end of the edge-counted backlight link.
package ecb_pkg;
  typedef enum logic [4:0] {
    ECB_IDLE = 5'h01,
    ECB_PULSE_LO = 5'h02,
    ECB_PULSE_HI = 5'h04,
    ECB_HOLD_HI = 5'h08,
    ECB_HOLD_LO = 5'h10
  } ecb_host_state_type;
endpackage

// ==== edge_count_backlight_ctrl_tb.sv ====
// Self-checking bench: APB commands into the host end, device outputs judged.
`timescale 1ns/1ps
module edge_count_backlight_ctrl_tb;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic hr_low = 1'b0;
  logic sup_high = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, busy, awake, bl_on, fade_en, fade_in, ra, rb, rda, rdb, mode, sw;
  logic [1:0] floor_code;
  logic [4:0] lvl;
  logic [8:0] target;
  logic [3:0] vcode;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  ecb_link_if link ();
  ecb_host #(.LAT_HOLD_CYCLES(216), .EDGE_LOW_CYCLES(4),
    .EDGE_HIGH_CYCLES(4)) u_ecb_host (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .busy_out(busy), .link(link));
  ecb_dev #(.LAT_CYCLES(200), .OFF_CYCLES(200)) u_ecb_dev (.ref_clk_in(ref_clk_in),
    .srst_in(srst_in), .link(link), .cp_headroom_low_in(hr_low),
    .cp_supply_high_in(sup_high), .awake_out(awake), .backlight_on_out(bl_on),
    .fade_en_out(fade_en), .fade_in_out(fade_in), .floor_code_out(floor_code),
    .led_level_code_out(lvl), .led_target_tenth_ma_out(target), .regulator_a_on_out(ra),
    .regulator_b_on_out(rb), .regulator_a_discharge_out(rda),
    .regulator_b_discharge_out(rdb), .regulator_voltage_code_out(vcode),
    .cp_mode_1p5x_out(mode), .cp_switch_out(sw));
  ecb_link_asserts u_ecb_link_asserts (.ref_clk_in(ref_clk_in),
    .srst_in(srst_in), .ctrl_pin(link.ctrl_pin), .awake_out(awake),
    .backlight_on_out(bl_on), .fade_en_out(fade_en), .fade_in_out(fade_in),
    .floor_code_out(floor_code), .led_level_code_out(lvl), .led_target_tenth_ma_out(target),
    .regulator_a_on_out(ra), .regulator_b_on_out(rb), .regulator_a_discharge_out(rda),
    .regulator_b_discharge_out(rdb), .cp_headroom_low_in(hr_low),
    .cp_mode_1p5x_out(mode), .cp_switch_out(sw));
  always #5 ref_clk_in = ~ref_clk_in;
  task automatic complete_run();
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    @(posedge ref_clk_in);
    while (pready !== 1'b1)
      @(posedge ref_clk_in);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waiting on the busy flag rather than a fixed count keeps the bench honest on hold times.
  task automatic wr_wait(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    apb(1'b0, 8'h08, 32'h0000_0000, r, e);
    chk({r[0], busy}, 2'h3);
    do
      apb(1'b0, 8'h08, 32'h0000_0000, r, e);
    while (r[0] !== 1'b0);
    chk(busy, 1'b0);
  endtask
  task automatic send(input logic [2:0] a, input logic [3:0] d, input logic wa);
    wr_wait(8'h00, {23'h00_0000, wa, 1'b0, a, d});
  endtask
  task automatic s_defaults();
    chk(awake, 1'b0);
    chk(vcode, 4'h8);
    chk(lvl, 5'h14);
    chk(floor_code, 2'h0);
    chk({ra, rb, rda, rdb}, 4'h3);
  endtask
  task automatic s_wake();
    send(3'h0, 4'h3, 1'b0);
    chk({awake, bl_on, fade_en, fade_in}, 4'hF);
    wr_wait(8'h04, 32'h0000_0001);
    chk({awake, bl_on}, 2'h0);
    send(3'h0, 4'h0, 1'b0);
    chk({awake, bl_on, fade_en, fade_in, lvl}, {4'hC, 5'h14});
  endtask
  task automatic s_addr0();
    for (int d = 0; d < 8; d++)
    begin
      send(3'h0, d[3:0], 1'b1);
      chk(bl_on, d < 4);
      chk({fade_en, fade_in}, d[1:0]);
    end
  endtask
  task automatic s_floor();
    send(3'h0, 4'h6, 1'b1);
    for (int f = 0; f < 4; f++)
    begin
      send(3'h1, f[3:0], 1'b1);
      chk(floor_code, f[1:0]);
      chk(target, f == 0 ? 32'h0000_0005 : 32'h0000_000A * f);
    end
    send(3'h0, 4'h0, 1'b1);
  endtask
  task automatic s_level();
    send(3'h2, 4'h1, 1'b1);
    chk(lvl, 5'h14);
    send(3'h3, 4'hF, 1'b1);
    chk({lvl, target}, {5'h1F, 9'h136});
    send(3'h2, 4'h0, 1'b1);
    send(3'h3, 4'h5, 1'b1);
    chk({lvl, target}, {5'h05, 9'h031});
  endtask
  task automatic s_regs();
    for (int d = 0; d < 4; d++)
    begin
      send(3'h4, d[3:0], 1'b1);
      chk({ra, rb, rda, rdb}, {d[1:0], ~d[1:0]});
    end
    for (int v = 0; v < 16; v++)
    begin
      send(3'h5, v[3:0], v == 0);
      chk(vcode, v[3:0]);
    end
    send(3'h6, 4'h0, 1'b1);
    chk(vcode, 4'h0);
  endtask
  task automatic s_bus();
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h0C, 32'h0000_0000, r, e);
    chk({e, r}, {1'b1, 32'h0000_0000});
    send(3'h1, 4'hF, 1'b1);
    chk(floor_code, 2'h3);
    apb(1'b0, 8'h00, 32'h0000_0000, r, e);
    chk({e, r}, {1'b0, 32'h0000_0113});
    apb(1'b0, 8'h08, 32'h0000_0000, r, e);
    chk({e, r}, {1'b0, 32'h0000_0002});
  endtask
  task automatic s_pump();
    int n;
    n = 0;
    hr_low <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    chk(mode, 1'b1);
    while (sw !== 1'b0)
      @(posedge ref_clk_in);
    while (sw !== 1'b1)
      @(posedge ref_clk_in);
    while (sw === 1'b1)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    chk(n, 55);
    hr_low <= 1'b0;
    sup_high <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    chk({mode, sw}, 2'h0);
  endtask
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_fail++;
      complete_run();
    end
  end
  initial
  begin
    repeat (3) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    @(posedge ref_clk_in);
    s_defaults();
    s_wake();
    s_addr0();
    s_floor();
    s_level();
    s_regs();
    s_bus();
    s_pump();
    complete_run();
  end
endmodule
